// [adcof_chk_assertions.sv]
// Port checker for the converter output formatter
`default_nettype none

module adcof_chk
	import adcof_pkg::*;
(
	input wire logic              mclk_in,                       // Clock
	input wire logic              reset_n_in,                    // Reset, low
	input wire logic              reg_rd_in,                     // Read strobe
	input wire logic [DATA_W-1:0] reg_rdata_out,                 // Read data
	input wire logic              core_take_out,                 // Sample taken
	input wire logic [SMP_W-1:0]  channel_a_bus_out,             // A word
	input wire logic              channel_a_bus_oe_out,          // A enable
	input wire logic [SMP_W-1:0]  channel_b_bus_out,             // B word
	input wire logic              channel_b_bus_oe_out,          // B enable
	input wire logic              single_ended_output_clock_out, // CMOS clock
	input wire logic [PAIR_W-1:0] ddr_a_out,                     // A pairs
	input wire logic [PAIR_W-1:0] ddr_b_out,                     // B pairs
	input wire logic              ddr_oe_out,                    // DDR on
	input wire logic              differential_output_clock_out  // DDR clock
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================
	// Assertions, one clock domain
	// ==========================================
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);

	AST_TAKE_PERIOD: assert property (core_take_out |=> !core_take_out[*3] ##1 core_take_out)
		else $error("sample take spacing wrong");
	AST_RDATA_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == '0)
		else $error("read data outside its cycle");
	AST_SE_QUIET: assert property (ddr_oe_out && $past(ddr_oe_out) |-> !single_ended_output_clock_out)
		else $error("cmos clock runs in ddr");
	AST_DIFF_QUIET: assert property (!ddr_oe_out && !$past(ddr_oe_out) |-> !differential_output_clock_out)
		else $error("ddr clock runs in cmos");
	// Clock shape checked over one whole sample period
	AST_DDR_CLK: assert property ((core_take_out && ddr_oe_out && $past(ddr_oe_out)) ##1 ddr_oe_out[*4]
		|-> $past(differential_output_clock_out, 3) && $past(differential_output_clock_out, 2)
		&& !$past(differential_output_clock_out) && !differential_output_clock_out)
		else $error("ddr clock phase wrong");
	AST_SE_CLK: assert property ((core_take_out && !ddr_oe_out && !$past(ddr_oe_out)) ##1 !ddr_oe_out[*4]
		|-> !$past(single_ended_output_clock_out, 3) && single_ended_output_clock_out)
		else $error("cmos clock phase wrong");
	AST_A_HOLD: assert property (channel_a_bus_oe_out && $past(channel_a_bus_oe_out)
		&& !$stable(channel_a_bus_out) |-> $past(core_take_out))
		else $error("channel a word moved mid period");
	AST_B_SWITCH: assert property (channel_b_bus_oe_out && $past(channel_b_bus_oe_out)
		&& !$stable(channel_b_bus_out) |-> $past(core_take_out) || $past(core_take_out, 3))
		else $error("channel b word moved off phase");
	AST_PAIR_SWITCH: assert property (ddr_oe_out && $past(ddr_oe_out)
		&& !$stable({ddr_a_out, ddr_b_out}) |-> $past(core_take_out) || $past(core_take_out, 3))
		else $error("ddr pairs moved off phase");

	COV_DDR: cover property (core_take_out && ddr_oe_out);
	COV_SHARED: cover property (!channel_a_bus_oe_out && channel_b_bus_oe_out);
	COV_READ: cover property (reg_rd_in);
endmodule // adcof_chk

bind adcof_top adcof_chk u_chk (.mclk_in, .reset_n_in, .reg_rd_in, .reg_rdata_out,
	.core_take_out, .channel_a_bus_out, .channel_a_bus_oe_out, .channel_b_bus_out,
	.channel_b_bus_oe_out, .single_ended_output_clock_out, .ddr_a_out, .ddr_b_out,
	.ddr_oe_out, .differential_output_clock_out);

`default_nettype wire

// [adcof_delay_line.sv]
// Sample delay line with selectable output tap
`default_nettype none

module adcof_delay_line (
	input  wire logic                 mclk_in,     // Master clock
	input  wire logic                 reset_n_in,  // Async reset, low
	input  wire logic                 shift_in,    // Advance one sample
	input  wire logic                 low_lat_in,  // Take the short tap
	input  wire adcof_pkg::adcof_pair_t din_in,    // New sample pair
	output      adcof_pkg::adcof_pair_t dout_out   // Delayed sample pair
);
	import adcof_pkg::*;

	adcof_pair_t mem_q [LAT_NORM];

	// ==========================================================
	// Shift chain, one stage per sample period
	// ==========================================================
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < LAT_NORM; i++) begin
				mem_q[i] <= '0;
			end
		end else if (shift_in) begin
			mem_q[0] <= din_in;
			for (int i = 1; i < LAT_NORM; i++) begin
				mem_q[i] <= mem_q[i-1];
			end
		end
	end

	// Tap choice; the long tap stands for the processing path
	assign dout_out = low_lat_in ? mem_q[LAT_LOW-1] : mem_q[LAT_NORM-1];  // [R20]

endmodule // adcof_delay_line

`default_nettype wire

// [adcof_pkg.sv]
// Package for the converter output formatter: constants, register map and carrier types
`default_nettype none

package adcof_pkg;

	// ==========================================================
	// Widths
	// ==========================================================
	localparam int SMP_W  = 12;              // Sample word width
	localparam int PAIR_W = SMP_W / 2;       // Differential pairs per channel
	localparam int ADDR_W = 4;               // Register port address width
	localparam int DATA_W = 32;              // Register port data width

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int MCLK_NS   = 5;                     // Master clock period
	localparam int SAMPLE_NS = 20;                    // Sample period on the pins
	localparam int PHASES    = SAMPLE_NS / MCLK_NS;   // Master cycles per sample
	localparam logic [1:0] PH_LAST = 2'(PHASES - 1);  // Last phase of a sample
	localparam logic [1:0] PH_HALF = 2'(PHASES / 2);  // First phase of second half
	localparam logic [1:0] PH_PRE  = 2'(PHASES / 2 - 1); // Phase before second half
	localparam int LAT_NORM  = 14;                    // Latency, processing path
	localparam int LAT_LOW   = 10;                    // Latency, bypass path

	// ==========================================================
	// Register map
	// ==========================================================
	localparam logic [ADDR_W-1:0] REG_CFG  = 4'h0;   // Mode configuration
	localparam logic [ADDR_W-1:0] REG_DRV  = 4'h4;   // Buffer settings
	localparam logic [ADDR_W-1:0] REG_STAT = 4'h8;   // Effective state, read only
	localparam int CFG_BITS = 7;
	localparam int DRV_BITS = 8;
	localparam int STAT_BITS = 8;
	localparam logic [CFG_BITS-1:0] CFG_RST = 7'h00; // CMOS, offset binary
	localparam logic [DRV_BITS-1:0] DRV_RST = 8'h00; // 3.5 mA, open, default drive

	// ==========================================================
	// Codes
	// ==========================================================
	localparam logic [SMP_W-1:0] OB_POS = 12'h7FF;   // Offset binary, positive clamp
	localparam logic [SMP_W-1:0] OB_NEG = 12'h000;   // Offset binary, negative clamp
	localparam logic [SMP_W-1:0] TC_POS = 12'h3FF;   // Two-complement, positive clamp
	localparam logic [SMP_W-1:0] TC_NEG = 12'h400;   // Two-complement, negative clamp
	localparam logic [2:0] PM_NORMAL = 3'h0;
	localparam logic [2:0] PM_OFF_A  = 3'h1;
	localparam logic [2:0] PM_OFF_B  = 3'h2;
	localparam logic [2:0] PM_OFF_AB = 3'h3;
	localparam logic [2:0] PM_DOWN   = 3'h4;
	localparam logic [2:0] PM_MUX    = 3'h7;

	// ==========================================================
	// Carrier types
	// ==========================================================
	typedef struct packed {
		logic             ovr_pos;   // Positive overdrive
		logic             ovr_neg;   // Negative overdrive
		logic [SMP_W-1:0] code;      // Offset-binary core code
	} adcof_smp_t;

	typedef struct packed {
		adcof_smp_t a;
		adcof_smp_t b;
	} adcof_pair_t;

	typedef struct packed {
		logic       pin_ctrl;        // Take modes from pins
		logic [2:0] power_mode;      // Power and bus mode field
		logic       low_latency;     // Bypass processing
		logic       twos;            // Two-complement format
		logic       ddr;             // Double-data-rate signalling
	} adcof_cfg_t;

	typedef struct packed {
		logic       clk_strong;      // Raised clock drive
		logic       data_strong;     // Raised data drive
		logic [2:0] term;            // Termination selections
		logic       cur_double;      // Doubled buffer current
		logic [1:0] cur_sel;         // 0:3.5 1:2.5 2:4.5 3:1.75 mA
	} adcof_drv_t;

endpackage : adcof_pkg

`default_nettype wire

// [adcof_rx_model.sv]
// Receiver model capturing words on the output clocks
`default_nettype none

module adcof_rx_model (
	input  wire logic        mclk_in,    // Sampling clock
	input  wire logic        se_clk_in,  // CMOS clock
	input  wire logic        df_clk_in,  // DDR clock
	input  wire logic [11:0] bus_a_in,   // A word
	input  wire logic [11:0] bus_b_in,   // B word
	input  wire logic [5:0]  pair_a_in,  // A pairs
	input  wire logic [5:0]  pair_b_in,  // B pairs
	output var  logic [11:0] word_a_out, // CMOS A capture
	output var  logic [11:0] word_b_out, // CMOS B capture
	output var  logic [11:0] ddr_a_out,  // DDR A word
	output var  logic [11:0] ddr_b_out   // DDR B word
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       se_q, df_q;
	logic [5:0] ev_a, ev_b;

	// Even bits go to 2i, odd to 2i+1
	function automatic logic [11:0] weave(input logic [5:0] e, input logic [5:0] o);
		for (int i = 0; i < 6; i++) begin
			weave[2*i] = e[i];
			weave[2*i+1] = o[i];
		end
	endfunction

	// Clock edges found by oversampling, as a fabric receiver would
	always @(posedge mclk_in) begin
		se_q <= se_clk_in;
		df_q <= df_clk_in;
		if (se_clk_in && !se_q) begin
			word_a_out <= bus_a_in;
			word_b_out <= bus_b_in;
		end
		if (df_clk_in && !df_q) begin
			ev_a <= pair_a_in;
			ev_b <= pair_b_in;
		end
		if (!df_clk_in && df_q) begin
			ddr_a_out <= weave(ev_a, pair_a_in);
			ddr_b_out <= weave(ev_b, pair_b_in);
		end
	end
endmodule // adcof_rx_model

`default_nettype wire

// [adcof_top.sv]
// Output formatter of a dual-channel 12-bit sampling converter
//
// Contract
// R1 - Two 12-bit words plus shared clock
// R2 - Signalling chosen by bit or strap
// R3 - CMOS: every bit on own pin
// R4 - Receiver captures CMOS on rising edge
// R5 - DDR: two bits per pair per cycle
// R6 - Even bits rising, odd bits falling
// R7 - Receiver captures DDR on both edges
// R8 - Current 3.5 mA default, three others
// R9 - Doubling bit doubles data and clock
// R10 - Three free termination selections
// R11 - Raised drive for data and clock
// R12 - Format chosen by bit or strap
// R13 - Positive clamp 0x7FF or 0x3FF
// R14 - Negative clamp 0x000 or 0x400
// R15 - Shared bus only in CMOS
// R16 - Shared bus on B, A three-stated
// R17 - Shared bus only below 65 MSPS
// R18 - Shared bus by field or pins
// R19 - Field value 111 or pins high
// R20 - Latency 14, or 10 when bypassed
// R21 - Bypass disables processing features
// R22 - Shared bus: A then B
//
// The address map and the plain strobed port were chosen for this implementation.
`default_nettype none

module adcof_top (
	input  wire logic                         mclk_in,        // Master clock, 200 MHz
	input  wire logic                         reset_n_in,     // Async reset, low
	// Register port
	input  wire logic [adcof_pkg::ADDR_W-1:0] reg_addr_in,    // Byte address
	input  wire logic [adcof_pkg::DATA_W-1:0] reg_wdata_in,   // Write data
	input  wire logic                         reg_wr_in,      // Write strobe
	input  wire logic                         reg_rd_in,      // Read strobe
	output      logic [adcof_pkg::DATA_W-1:0] reg_rdata_out,  // Read data, next cycle
	// Converter core
	input  wire adcof_pkg::adcof_pair_t       core_smp_in,    // Raw samples, both channels
	output      logic                         core_take_out,  // Sample taken this cycle
	// Strap and mode pins
	input  wire logic                         parallel_config_strap_pin_in, // Strap
	input  wire logic                         mode_pin_one_in,    // Mode pin 1 (msb)
	input  wire logic                         mode_pin_two_in,    // Mode pin 2
	input  wire logic                         mode_pin_three_in,  // Mode pin 3 (lsb)
	// CMOS outputs
	output      logic [adcof_pkg::SMP_W-1:0]  channel_a_bus_out,  // Channel A data
	output      logic                         channel_a_bus_oe_out, // A drive enable
	output      logic [adcof_pkg::SMP_W-1:0]  channel_b_bus_out,  // Channel B data
	output      logic                         channel_b_bus_oe_out, // B drive enable
	output      logic                         single_ended_output_clock_out, // CMOS clock
	// DDR outputs
	output      logic [adcof_pkg::PAIR_W-1:0] ddr_a_out,          // Channel A pairs
	output      logic [adcof_pkg::PAIR_W-1:0] ddr_b_out,          // Channel B pairs
	output      logic                         ddr_oe_out,         // DDR buffers on
	output      logic                         differential_output_clock_out, // DDR clock
	// Stored buffer settings and processing enable
	output      adcof_pkg::adcof_drv_t        drv_set_out,        // Analog buffer settings
	output      logic                         proc_path_en_out    // Processing usable
);
	import adcof_pkg::*;

	// ==========================================================
	// Helper functions
	// ==========================================================
	// Even or odd bits of a word, packed onto the pairs
	function automatic logic [PAIR_W-1:0] pick_bits(input logic [SMP_W-1:0] w,
		input logic odd);
		logic [PAIR_W-1:0] r;
		r = '0;
		for (int i = 0; i < PAIR_W; i++) begin
			r[i] = w[2*i + int'(odd)];
		end
		return r;
	endfunction

	// Final code with format and overdrive clamp
	function automatic logic [SMP_W-1:0] fmt_code(input adcof_smp_t s, input logic twos);
		logic [SMP_W-1:0] r;
		r = twos ? {~s.code[SMP_W-1], s.code[SMP_W-2:0]} : s.code;
		if (s.ovr_pos) begin
			r = twos ? TC_POS : OB_POS;             // [R13]
		end else if (s.ovr_neg) begin
			r = twos ? TC_NEG : OB_NEG;             // [R14]
		end
		return r;
	endfunction

	// Output buffer of one channel turned off by the power field
	function automatic logic chan_off(input logic [2:0] pm, input logic is_b);
		logic r;
		unique case (pm)
			PM_OFF_A:  r = !is_b;
			PM_OFF_B:  r = is_b;
			PM_OFF_AB: r = 1'b1;
			PM_DOWN:   r = 1'b1;
			default:   r = 1'b0;
		endcase
		return r;
	endfunction

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	logic [3:0] pin_meta_q;
	logic [3:0] pin_sync_q;
	wire  [3:0] pin_raw = {parallel_config_strap_pin_in, mode_pin_one_in,
		mode_pin_two_in, mode_pin_three_in};

	// Two stages; only the second stage is read by logic
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= pin_raw;
			pin_sync_q <= pin_meta_q;
		end
	end

	// ==========================================================
	// Registers
	// ==========================================================
	adcof_cfg_t        cfg_q;
	adcof_drv_t        drv_q;
	logic [DATA_W-1:0] rdata_q;
	logic [STAT_BITS-1:0] stat_w;

	wire wr_cfg = reg_wr_in && (reg_addr_in == REG_CFG);
	wire wr_drv = reg_wr_in && (reg_addr_in == REG_DRV);

	// Software writes; reserved bits are dropped
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cfg_q <= adcof_cfg_t'(CFG_RST);
			drv_q <= adcof_drv_t'(DRV_RST);
		end else begin
			if (wr_cfg) begin
				cfg_q <= adcof_cfg_t'(reg_wdata_in[CFG_BITS-1:0]);
			end
			if (wr_drv) begin
				drv_q <= adcof_drv_t'(reg_wdata_in[DRV_BITS-1:0]);  // [R8] [R9] [R10] [R11]
			end
		end
	end

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_q <= '0;
		end else if (reg_rd_in) begin
			unique case (reg_addr_in)
				REG_CFG:  rdata_q <= DATA_W'(cfg_q);
				REG_DRV:  rdata_q <= DATA_W'(drv_q);
				REG_STAT: rdata_q <= DATA_W'(stat_w);
				default:  rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign drv_set_out   = drv_q;

	// ==========================================================
	// Effective modes
	// ==========================================================
	// Strap selects both signalling and format under pin control
	wire       eff_ddr  = cfg_q.pin_ctrl ? pin_sync_q[3] : cfg_q.ddr;    // [R2]
	wire       eff_twos = cfg_q.pin_ctrl ? pin_sync_q[3] : cfg_q.twos;   // [R12]
	wire [2:0] eff_pm   = cfg_q.pin_ctrl ? pin_sync_q[2:0] : cfg_q.power_mode; // [R18]
	// Field 111 gives the shared bus, never with DDR
	wire       mux_on   = (eff_pm == PM_MUX) && !eff_ddr;                // [R19] [R15]
	wire       low_lat  = cfg_q.low_latency;

	// Processing features are held off while bypassed
	assign proc_path_en_out = !low_lat;                                  // [R21]

	// ==========================================================
	// Sample phase and pipeline
	// ==========================================================
	logic [1:0]   ph_q;
	adcof_pair_t  dly_w;
	wire          last_ph = (ph_q == PH_LAST);
	wire          pre_ph  = (ph_q == PH_PRE);
	wire [1:0]    ph_d    = last_ph ? 2'h0 : ph_q + 2'h1;

	// Phase counter; one sample per PHASES master cycles
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ph_q <= '0;
		end else begin
			ph_q <= ph_d;
		end
	end

	assign core_take_out = last_ph;

	adcof_delay_line u_dly (
		.mclk_in    (mclk_in),
		.reset_n_in (reset_n_in),
		.shift_in   (last_ph),
		.low_lat_in (low_lat),
		.din_in     (core_smp_in),
		.dout_out   (dly_w)
	);

	wire [SMP_W-1:0] fmt_a = fmt_code(dly_w.a, eff_twos);
	wire [SMP_W-1:0] fmt_b = fmt_code(dly_w.b, eff_twos);

	// Channel B word held for the second half of a shared-bus period
	logic [SMP_W-1:0] hold_b_q;

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			hold_b_q <= '0;
		end else if (last_ph) begin
			hold_b_q <= fmt_b;
		end
	end

	// ==========================================================
	// CMOS path
	// ==========================================================
	logic [SMP_W-1:0] bus_a_q;
	logic [SMP_W-1:0] bus_b_q;
	logic             se_clk_q;

	// Full words each sample; shared bus puts A first, then B
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			bus_a_q <= '0;
			bus_b_q <= '0;
		end else if (last_ph) begin
			bus_a_q <= fmt_a;                                   // [R1] [R3]
			bus_b_q <= mux_on ? fmt_a : fmt_b;                  // [R16] [R22]
		end else if (pre_ph && mux_on) begin
			bus_b_q <= hold_b_q;                                // [R22]
		end
	end

	// Clock rises mid-word so a rising-edge receiver has margin
	wire se_clk_d = mux_on ? ph_d[0] : (ph_d >= PH_HALF);      // [R4] [R22]

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			se_clk_q <= 1'b0;
		end else begin
			se_clk_q <= !eff_ddr && se_clk_d;                   // [R1]
		end
	end

	// Shared bus doubles the word rate, so the sample period is kept long
	assign channel_a_bus_out    = bus_a_q;
	assign channel_a_bus_oe_out = !eff_ddr && !mux_on && !chan_off(eff_pm, 1'b0); // [R16]
	assign channel_b_bus_out    = bus_b_q;
	assign channel_b_bus_oe_out = !eff_ddr && (mux_on || !chan_off(eff_pm, 1'b1)); // [R16]
	assign single_ended_output_clock_out = se_clk_q;

	// ==========================================================
	// DDR path
	// ==========================================================
	logic [PAIR_W-1:0] pair_a_q;
	logic [PAIR_W-1:0] pair_b_q;
	logic              diff_clk_q;

	// Even bits with the rising clock, odd bits with the falling one
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pair_a_q <= '0;
			pair_b_q <= '0;
		end else if (last_ph) begin
			pair_a_q <= pick_bits(fmt_a, 1'b0);                 // [R5] [R6]
			pair_b_q <= pick_bits(fmt_b, 1'b0);                 // [R6]
		end else if (pre_ph) begin
			pair_a_q <= pick_bits(bus_a_q, 1'b1);               // [R6]
			pair_b_q <= pick_bits(hold_b_q, 1'b1);              // [R6]
		end
	end

	// Clock high in the first half; both edges carry data for the receiver
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			diff_clk_q <= 1'b0;
		end else begin
			diff_clk_q <= eff_ddr && (ph_d < PH_HALF);          // [R5] [R7]
		end
	end

	assign ddr_a_out  = pair_a_q;
	assign ddr_b_out  = pair_b_q;
	assign ddr_oe_out = eff_ddr && (eff_pm != PM_DOWN);
	assign differential_output_clock_out = diff_clk_q;

	// ==========================================================
	// Status word
	// ==========================================================
	assign stat_w = {se_clk_q || diff_clk_q, !low_lat, eff_pm, mux_on, eff_twos, eff_ddr};

endmodule // adcof_top

`default_nettype wire

// [tb.sv]
// Self-checking bench for the converter output formatter
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
	$display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end

module tb;
	import adcof_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic        mclk_in = 0, reset_n_in = 0, wr = 0, rd = 0, strap = 0;
	logic [3:0]  addr = '0;
	logic [31:0] wdat = '0, rdat;
	logic [2:0]  mp = '0;
	adcof_pair_t smp = '0;
	adcof_drv_t  drv;
	logic        take, a_oe, b_oe, se_clk, ddr_oe, df_clk, ppe;
	logic [11:0] bus_a, bus_b, ma, mb, da, db;
	logic [5:0]  pa, pb;
	int          errors = 0, comparisons = 0;
	// Rows: cfg, overdrive nibble, core code, expected word
	localparam logic [35:0] ROWS [9] = '{36'h00_0_123_123, 36'h02_0_123_923,
		36'h00_2_5AB_7FF, 36'h02_2_5AB_3FF, 36'h00_1_5AB_000, 36'h02_1_5AB_400,
		36'h01_0_A5C_A5C, 36'h03_0_0A5_8A5, 36'h04_0_3C3_3C3};
	// Buffer enables {a, b, ddr} for power field values 001 to 100 in CMOS
	localparam logic [2:0] PM_OE [4] = '{3'b010, 3'b100, 3'b000, 3'b000};

	adcof_top uut (.mclk_in, .reset_n_in, .reg_addr_in(addr), .reg_wdata_in(wdat),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .core_smp_in(smp),
		.core_take_out(take), .parallel_config_strap_pin_in(strap),
		.mode_pin_one_in(mp[2]), .mode_pin_two_in(mp[1]), .mode_pin_three_in(mp[0]),
		.channel_a_bus_out(bus_a), .channel_a_bus_oe_out(a_oe),
		.channel_b_bus_out(bus_b), .channel_b_bus_oe_out(b_oe),
		.single_ended_output_clock_out(se_clk), .ddr_a_out(pa), .ddr_b_out(pb),
		.ddr_oe_out(ddr_oe), .differential_output_clock_out(df_clk),
		.drv_set_out(drv), .proc_path_en_out(ppe));
	adcof_rx_model u_rx (.mclk_in, .se_clk_in(se_clk), .df_clk_in(df_clk),
		.bus_a_in(bus_a), .bus_b_in(bus_b), .pair_a_in(pa), .pair_b_in(pb),
		.word_a_out(ma), .word_b_out(mb), .ddr_a_out(da), .ddr_b_out(db));

	// ==========================================
	// Clock and bus tasks
	// ==========================================
	initial begin
		forever #2.5 mclk_in = ~mclk_in;
	end
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		addr <= a;
		wdat <= d;
		wr <= 1'b1;
		@(posedge mclk_in);
		wr <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe
	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_in);
		rd <= 1'b0;
		@(negedge mclk_in);
		d = rdat;
	endtask
	task automatic print_verdict;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Bounded wait for the phase-3 take cycle
	task automatic wait_take;
		for (int i = 0; i < 9; i++) begin
			@(negedge mclk_in);
			if (take === 1'b1) return;
		end
		errors++;
		print_verdict();
	endtask
	// New word at a take edge, edges counted until it shows
	task automatic latency(input logic [31:0] cfg, input int lat);
		int n;
		reg_write(REG_CFG, cfg);
		smp <= '0;
		repeat (80) @(posedge mclk_in);
		wait_take();
		repeat (3) @(posedge mclk_in);
		smp <= {14'h0ABC, 14'h0ABC};
		for (n = 0; n < 100; n++) begin
			@(negedge mclk_in);
			if (bus_b === 12'hABC) break;
		end
		// A word that never shows is a hang, not a latency figure
		if (n == 100) begin
			errors++;
			print_verdict();
		end else begin
			`CHK((n - 1) / 4, lat)
			$display("test latency %0d done", lat);
		end
	endtask

	// ==========================================
	// Main sequence
	// ==========================================
	initial begin
		logic [35:0] r;
		logic [31:0] d;
		logic [7:0]  v;
		repeat (12) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		reg_read(REG_CFG, d);
		`CHK(d, 32'(CFG_RST))
		`CHK(drv, DRV_RST)
		`CHK(ppe, 1'b1)
		for (int i = 0; i < 8; i++) begin
			v = 8'(i * 37);
			reg_write(REG_DRV, {24'h0, v});
			reg_read(REG_DRV, d);
			`CHK(d, {24'h0, v})
			`CHK(drv, v)
		end
		reg_write(4'hC, 32'hFF);
		reg_read(4'hC, d);
		`CHK(d, 32'h0)
		$display("test registers done");
		for (int i = 0; i < 9; i++) begin
			r = ROWS[i];
			reg_write(REG_CFG, {24'h0, r[35:28]});
			smp <= {r[25:12], r[25:12]};
			repeat (80) @(posedge mclk_in);
			reg_read(REG_STAT, d);
			`CHK(d[1:0], r[29:28])
			`CHK(ddr_oe, r[28])
			`CHK(ppe, !r[30])
			`CHK(r[28] ? da : ma, r[11:0])
			`CHK(r[28] ? db : mb, r[11:0])
		end
		$display("test rows done");
		latency(32'h0, LAT_NORM);
		latency(32'h4, LAT_LOW);
		reg_write(REG_CFG, 32'h38); // shared bus only at the fixed 50 MSPS rate
		smp <= {14'h0111, 14'h0222};
		repeat (80) @(posedge mclk_in);
		`CHK({a_oe, b_oe}, 2'b01)
		wait_take();
		`CHK(bus_b, 12'h222)
		repeat (2) @(negedge mclk_in);
		`CHK(bus_b, 12'h111)
		reg_read(REG_STAT, d);
		`CHK(d[2], 1'b1)
		reg_write(REG_CFG, 32'h39);
		reg_read(REG_STAT, d);
		`CHK({d[2], ddr_oe}, 2'b01)
		reg_write(REG_CFG, 32'h40);
		mp <= 3'b111;
		reg_read(REG_STAT, d);
		repeat (8) @(posedge mclk_in);
		`CHK(a_oe, 1'b0)
		strap <= 1'b1;
		repeat (8) @(posedge mclk_in);
		reg_read(REG_STAT, d);
		`CHK(d[2:0], 3'b011)
		$display("test shared bus done");
		// Field values 001 to 100 never give the shared bus; they gate the buffers
		for (int i = 1; i < 5; i++) begin
			reg_write(REG_CFG, {26'h0, 3'(i), 3'h0});
			@(negedge mclk_in);
			`CHK({a_oe, b_oe, ddr_oe}, PM_OE[i-1])
		end
		$display("test power modes done");
		// Reset in mid-run drops every stored setting back to its default
		reg_write(REG_DRV, 32'hFF);
		reset_n_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		`CHK(drv, DRV_RST)
		`CHK({bus_b, se_clk}, 13'h0)
		reset_n_in <= 1'b1;
		reg_read(REG_CFG, d);
		`CHK(d, 32'(CFG_RST))
		`CHK(ddr_oe, 1'b0)
		$display("test reset done");
		print_verdict();
	end
endmodule // tb

`default_nettype wire
